// ===== hdl/iop_map.vh
// Purpose: Register indices, reset values and field widths of the I/O port block.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef IOP_MAP_VH
`define IOP_MAP_VH
// ==========================================================================
// Register indices
`define IOP_IDX_P0_LEVEL     16'h5200
`define IOP_IDX_PORT0_OUTPUT_VALUE       16'h5201
`define IOP_IDX_P0_DIR       16'h5202
`define IOP_IDX_P0_PULLUP    16'h5203
`define IOP_IDX_P0_HYST      16'h5204
`define IOP_IDX_P0_IRQ_EN    16'h5205
`define IOP_IDX_P0_IRQ_POL   16'h5206
`define IOP_IDX_P0_IRQ_PEND  16'h5207
`define IOP_IDX_P0_DEBOUNCE  16'h5208
`define IOP_IDX_P0_KEY_RST   16'h5209
`define IOP_IDX_P1_LEVEL     16'h5210
`define IOP_IDX_PORT1_OUTPUT_VALUE       16'h5211
`define IOP_IDX_P1_DIR       16'h5212
`define IOP_IDX_P1_PULLUP    16'h5213
`define IOP_IDX_P1_HYST      16'h5214
`define IOP_IDX_P1_IRQ_EN    16'h5215
`define IOP_IDX_P1_IRQ_POL   16'h5216
`define IOP_IDX_P1_IRQ_PEND  16'h5217
`define IOP_IDX_P2_LEVEL     16'h5220
`define IOP_IDX_PORT2_OUTPUT_VALUE       16'h5221
`define IOP_IDX_P2_DIR       16'h5222
`define IOP_IDX_P2_PULLUP    16'h5223
`define IOP_IDX_P2_HYST      16'h5224
`define IOP_IDX_P3_LEVEL     16'h5230
`define IOP_IDX_PORT3_OUTPUT_VALUE       16'h5231
`define IOP_IDX_P3_DIR       16'h5232
`define IOP_IDX_P3_PULLUP    16'h5233
`define IOP_IDX_P3_HYST      16'h5234
`define IOP_IDX_P0_FUNC      16'h52A0
`define IOP_IDX_P1_FUNC      16'h52A1
`define IOP_IDX_P2_FUNC      16'h52A2
`define IOP_IDX_P3_FUNC      16'h52A3
`define IOP_IDX_IRQ_STATUS   16'h52B0
`define IOP_IDX_IRQ_MASK     16'h52B1
// ==========================================================================
// Field widths
`define IOP_REG_W            8
`define IOP_P3_W             4
`define IOP_STAT_W           2
// ==========================================================================
// Reset values
`define IOP_RST_OUT          8'h00
`define IOP_RST_DIR          8'h00
`define IOP_RST_PULLUP       8'hFF
`define IOP_RST_HYST         8'h00
`define IOP_RST_IRQ          8'h00
`define IOP_RST_DEBOUNCE     8'h00
`define IOP_RST_KEY_RST      8'h00
`define IOP_RST_FUNC         8'h00
// Port 3 keeps only four bits in its output, direction, pull-up and hysteresis registers
`define IOP_RST_PORT3_OUTPUT_VALUE       4'h0
`define IOP_RST_P3_DIR       4'h0
`define IOP_RST_P3_PULLUP    4'hF
`define IOP_RST_P3_HYST      4'h0
`endif

// ===== hdl/iop_pin_sync.v
// Purpose: Two-flop synchroniser for a group of pins, plus an edge-history stage.
// Assumes: Pins are asynchronous to pclk.
// Notes:   Only sync_level and prev_level may be read outside.
`timescale 1ns/10ps
`default_nettype none
module iop_pin_sync #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// Pins and synchronised levels
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] sync_level,
	output reg  [WIDTH-1:0] prev_level
);
	reg [WIDTH-1:0] meta;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta       <= {WIDTH{1'b0}};
			sync_level <= {WIDTH{1'b0}};
			prev_level <= {WIDTH{1'b0}};
		end else begin
			meta       <= pin_in;
			sync_level <= meta;
			prev_level <= sync_level;
		end
	end
endmodule // iop_pin_sync
`default_nettype wire

// ===== hdl/iop_irq_port.v
// Purpose: Edge detection, pending flags and request line of one port.
// Assumes: Levels come already synchronised.
// Notes:   A new event wins over a clear in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module iop_irq_port #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// Synchronised pin levels
	input  wire [WIDTH-1:0] sync_level,
	input  wire [WIDTH-1:0] prev_level,
	// Controls
	input  wire [WIDTH-1:0] irq_enable_bits,
	input  wire [WIDTH-1:0] irq_polarity_bits,
	input  wire [WIDTH-1:0] clear_bits,
	// Status
	output reg  [WIDTH-1:0] irq_pending_bits,
	output reg              irq_request,
	output wire             event_seen
);
	wire [WIDTH-1:0] rise;
	wire [WIDTH-1:0] fall;
	wire [WIDTH-1:0] hit;
	wire [WIDTH-1:0] next_pending;

	assign rise = sync_level & ~prev_level;
	assign fall = ~sync_level & prev_level;
	// Polarity 1 picks the falling edge
	assign hit = irq_enable_bits &
		((irq_polarity_bits & fall) | (~irq_polarity_bits & rise));
	assign next_pending = (irq_pending_bits & ~clear_bits) | hit;
	assign event_seen = |hit;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pending_bits <= {WIDTH{1'b0}};
			irq_request      <= 1'b0;
		end else begin
			irq_pending_bits <= next_pending;
			irq_request      <= |next_pending;
		end
	end
endmodule // iop_irq_port
`default_nettype wire

// ===== hdl/iop_port_regs.v
// Purpose: APB register file, pin readback and interrupts of a four-port GPIO block.
// Assumes: Zero-wait style APB slave; one access cycle per transfer.
// Notes:   Register index times four is the byte address.
`timescale 1ns/10ps
`default_nettype none
`include "iop_map.vh"
module iop_port_regs #(
	parameter AW = 18
) (
	// Clock and reset
	input  wire          pclk,
	input  wire          presetn,
	// APB slave
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [AW-1:0] paddr,
	input  wire [31:0]   pwdata,
	input  wire [3:0]    pstrb,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	// Port pins
	input  wire [7:0]    port0_pin_in,
	input  wire [7:0]    port1_pin_in,
	input  wire [7:0]    port2_pin_in,
	input  wire [3:0]    port3_pin_in,
	output reg  [7:0]    port0_pin_out,
	output reg  [7:0]    port1_pin_out,
	output reg  [7:0]    port2_pin_out,
	output reg  [3:0]    port3_pin_out,
	output reg  [7:0]    port0_pin_oe,
	output reg  [7:0]    port1_pin_oe,
	output reg  [7:0]    port2_pin_oe,
	output reg  [3:0]    port3_pin_oe,
	// Pad controls
	output reg  [27:0]   pullup_enable,
	output reg  [27:0]   hysteresis_enable,
	output reg  [31:0]   function_select,
	output reg  [7:0]    debounce_control,
	output reg  [7:0]    key_reset_config,
	// Interrupts
	output wire          port0_irq,
	output wire          port1_irq,
	output reg           irq
);
	// ======================================================================
	// Bus decode
	wire [15:0] index;
	wire        wr_en;
	wire        rd_en;
	wire [7:0]  wbyte;

	assign index = paddr[17:2];
	// Access phase edge at which the transfer completes
	assign wr_en = psel & penable & pready & pwrite;
	assign rd_en = psel & penable & pready & ~pwrite;
	// Low lane only; other lanes are not storage
	assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;

	function wr_hit;
		input        en;
		input [15:0] idx;
		input [15:0] target;
		begin
			wr_hit = en && (idx == target);
		end
	endfunction

	// ======================================================================
	// Storage
	reg [7:0] port0_output_value;
	reg [7:0] port1_output_value;
	reg [7:0] port2_output_value;
	reg [3:0] port3_output_value;
	reg [7:0] p0_dir;
	reg [7:0] p1_dir;
	reg [7:0] p2_dir;
	reg [3:0] p3_dir;
	reg [7:0] p0_pullup;
	reg [7:0] p1_pullup;
	reg [7:0] p2_pullup;
	reg [3:0] p3_pullup;
	reg [7:0] p0_hyst;
	reg [7:0] p1_hyst;
	reg [7:0] p2_hyst;
	reg [3:0] p3_hyst;
	reg [7:0] p0_irq_en;
	reg [7:0] p1_irq_en;
	reg [7:0] p0_irq_pol;
	reg [7:0] p1_irq_pol;
	reg [7:0] p0_debounce;
	reg [7:0] p0_key_rst;
	reg [7:0] p0_func;
	reg [7:0] p1_func;
	reg [7:0] p2_func;
	reg [7:0] p3_func;
	reg [`IOP_STAT_W-1:0] irq_status;
	reg [`IOP_STAT_W-1:0] irq_mask;

	// ======================================================================
	// Pin synchronisers
	wire [7:0] p0_level;
	wire [7:0] p1_level;
	wire [7:0] p2_level;
	wire [3:0] p3_level;
	wire [7:0] p0_prev;
	wire [7:0] p1_prev;

	iop_pin_sync #(.WIDTH(8)) u_sync0 (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_in     (port0_pin_in),
		.sync_level (p0_level),
		.prev_level (p0_prev)
	);
	iop_pin_sync #(.WIDTH(8)) u_sync1 (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_in     (port1_pin_in),
		.sync_level (p1_level),
		.prev_level (p1_prev)
	);
	// Ports 2 and 3 have no edge logic
	iop_pin_sync #(.WIDTH(8)) u_sync2 (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_in     (port2_pin_in),
		.sync_level (p2_level),
		.prev_level ()
	);
	iop_pin_sync #(.WIDTH(`IOP_P3_W)) u_sync3 (
		.pclk       (pclk),
		.presetn    (presetn),
		.pin_in     (port3_pin_in),
		.sync_level (p3_level),
		.prev_level ()
	);

	// ======================================================================
	// Port interrupts
	wire [7:0] p0_pend;
	wire [7:0] p1_pend;
	wire [7:0] p0_clr;
	wire [7:0] p1_clr;
	wire       p0_event;
	wire       p1_event;

	assign p0_clr = wr_hit(wr_en, index, `IOP_IDX_P0_IRQ_PEND) ? wbyte : 8'h00;
	assign p1_clr = wr_hit(wr_en, index, `IOP_IDX_P1_IRQ_PEND) ? wbyte : 8'h00;

	iop_irq_port #(.WIDTH(8)) u_irq0 (
		.pclk              (pclk),
		.presetn           (presetn),
		.sync_level        (p0_level),
		.prev_level        (p0_prev),
		.irq_enable_bits   (p0_irq_en),
		.irq_polarity_bits (p0_irq_pol),
		.clear_bits        (p0_clr),
		.irq_pending_bits  (p0_pend),
		.irq_request       (port0_irq),
		.event_seen        (p0_event)
	);
	iop_irq_port #(.WIDTH(8)) u_irq1 (
		.pclk              (pclk),
		.presetn           (presetn),
		.sync_level        (p1_level),
		.prev_level        (p1_prev),
		.irq_enable_bits   (p1_irq_en),
		.irq_polarity_bits (p1_irq_pol),
		.clear_bits        (p1_clr),
		.irq_pending_bits  (p1_pend),
		.irq_request       (port1_irq),
		.event_seen        (p1_event)
	);

	// ======================================================================
	// Register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port0_output_value      <= `IOP_RST_OUT;
			port1_output_value      <= `IOP_RST_OUT;
			port2_output_value      <= `IOP_RST_OUT;
			port3_output_value      <= `IOP_RST_PORT3_OUTPUT_VALUE;
			p0_dir      <= `IOP_RST_DIR;
			p1_dir      <= `IOP_RST_DIR;
			p2_dir      <= `IOP_RST_DIR;
			p3_dir      <= `IOP_RST_P3_DIR;
			p0_pullup   <= `IOP_RST_PULLUP;
			p1_pullup   <= `IOP_RST_PULLUP;
			p2_pullup   <= `IOP_RST_PULLUP;
			p3_pullup   <= `IOP_RST_P3_PULLUP;
			p0_hyst     <= `IOP_RST_HYST;
			p1_hyst     <= `IOP_RST_HYST;
			p2_hyst     <= `IOP_RST_HYST;
			p3_hyst     <= `IOP_RST_P3_HYST;
			p0_irq_en   <= `IOP_RST_IRQ;
			p1_irq_en   <= `IOP_RST_IRQ;
			p0_irq_pol  <= `IOP_RST_IRQ;
			p1_irq_pol  <= `IOP_RST_IRQ;
			p0_debounce <= `IOP_RST_DEBOUNCE;
			p0_key_rst  <= `IOP_RST_KEY_RST;
			p0_func     <= `IOP_RST_FUNC;
			p1_func     <= `IOP_RST_FUNC;
			p2_func     <= `IOP_RST_FUNC;
			p3_func     <= `IOP_RST_FUNC;
			irq_mask    <= {`IOP_STAT_W{1'b0}};
		end else if (wr_en) begin
			// Pin-level and unlisted indices fall through untouched
			case (index)
			`IOP_IDX_PORT0_OUTPUT_VALUE:      port0_output_value      <= wbyte;
			`IOP_IDX_PORT1_OUTPUT_VALUE:      port1_output_value      <= wbyte;
			`IOP_IDX_PORT2_OUTPUT_VALUE:      port2_output_value      <= wbyte;
			`IOP_IDX_PORT3_OUTPUT_VALUE:      port3_output_value      <= wbyte[3:0];
			`IOP_IDX_P0_DIR:      p0_dir      <= wbyte;
			`IOP_IDX_P1_DIR:      p1_dir      <= wbyte;
			`IOP_IDX_P2_DIR:      p2_dir      <= wbyte;
			`IOP_IDX_P3_DIR:      p3_dir      <= wbyte[3:0];
			`IOP_IDX_P0_PULLUP:   p0_pullup   <= wbyte;
			`IOP_IDX_P1_PULLUP:   p1_pullup   <= wbyte;
			`IOP_IDX_P2_PULLUP:   p2_pullup   <= wbyte;
			`IOP_IDX_P3_PULLUP:   p3_pullup   <= wbyte[3:0];
			`IOP_IDX_P0_HYST:     p0_hyst     <= wbyte;
			`IOP_IDX_P1_HYST:     p1_hyst     <= wbyte;
			`IOP_IDX_P2_HYST:     p2_hyst     <= wbyte;
			`IOP_IDX_P3_HYST:     p3_hyst     <= wbyte[3:0];
			`IOP_IDX_P0_IRQ_EN:   p0_irq_en   <= wbyte;
			`IOP_IDX_P1_IRQ_EN:   p1_irq_en   <= wbyte;
			`IOP_IDX_P0_IRQ_POL:  p0_irq_pol  <= wbyte;
			`IOP_IDX_P1_IRQ_POL:  p1_irq_pol  <= wbyte;
			`IOP_IDX_P0_DEBOUNCE: p0_debounce <= wbyte;
			`IOP_IDX_P0_KEY_RST:  p0_key_rst  <= wbyte;
			`IOP_IDX_P0_FUNC:     p0_func     <= wbyte;
			`IOP_IDX_P1_FUNC:     p1_func     <= wbyte;
			`IOP_IDX_P2_FUNC:     p2_func     <= wbyte;
			`IOP_IDX_P3_FUNC:     p3_func     <= wbyte;
			`IOP_IDX_IRQ_MASK:    irq_mask    <= wbyte[1:0];
			default: begin
			end
			endcase
		end
	end

	// ======================================================================
	// Summary status: read clears, new event wins
	wire [`IOP_STAT_W-1:0] stat_set;
	wire                   stat_rd;
	wire [`IOP_STAT_W-1:0] next_irq_status;
	wire [`IOP_STAT_W-1:0] stat_clr;

	assign stat_set = {p1_event, p0_event};
	assign stat_rd = rd_en && (index == `IOP_IDX_IRQ_STATUS);
	// Clear only what the read returned; a bit set after capture must survive
	assign stat_clr = stat_rd ? prdata[`IOP_STAT_W-1:0] : {`IOP_STAT_W{1'b0}};
	assign next_irq_status = (irq_status & ~stat_clr) | stat_set;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= {`IOP_STAT_W{1'b0}};
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_mask);
		end
	end

	// ======================================================================
	// Read mux
	reg [7:0] rd_byte;

	always @* begin
		rd_byte = 8'h00;
		case (index)
		`IOP_IDX_P0_LEVEL:    rd_byte = p0_level;
		`IOP_IDX_P1_LEVEL:    rd_byte = p1_level;
		`IOP_IDX_P2_LEVEL:    rd_byte = p2_level;
		`IOP_IDX_P3_LEVEL:    rd_byte = {4'h0, p3_level};
		`IOP_IDX_PORT0_OUTPUT_VALUE:      rd_byte = port0_output_value;
		`IOP_IDX_PORT1_OUTPUT_VALUE:      rd_byte = port1_output_value;
		`IOP_IDX_PORT2_OUTPUT_VALUE:      rd_byte = port2_output_value;
		`IOP_IDX_PORT3_OUTPUT_VALUE:      rd_byte = {4'h0, port3_output_value};
		`IOP_IDX_P0_DIR:      rd_byte = p0_dir;
		`IOP_IDX_P1_DIR:      rd_byte = p1_dir;
		`IOP_IDX_P2_DIR:      rd_byte = p2_dir;
		`IOP_IDX_P3_DIR:      rd_byte = {4'h0, p3_dir};
		`IOP_IDX_P0_PULLUP:   rd_byte = p0_pullup;
		`IOP_IDX_P1_PULLUP:   rd_byte = p1_pullup;
		`IOP_IDX_P2_PULLUP:   rd_byte = p2_pullup;
		`IOP_IDX_P3_PULLUP:   rd_byte = {4'h0, p3_pullup};
		`IOP_IDX_P0_HYST:     rd_byte = p0_hyst;
		`IOP_IDX_P1_HYST:     rd_byte = p1_hyst;
		`IOP_IDX_P2_HYST:     rd_byte = p2_hyst;
		`IOP_IDX_P3_HYST:     rd_byte = {4'h0, p3_hyst};
		`IOP_IDX_P0_IRQ_EN:   rd_byte = p0_irq_en;
		`IOP_IDX_P1_IRQ_EN:   rd_byte = p1_irq_en;
		`IOP_IDX_P0_IRQ_POL:  rd_byte = p0_irq_pol;
		`IOP_IDX_P1_IRQ_POL:  rd_byte = p1_irq_pol;
		`IOP_IDX_P0_IRQ_PEND: rd_byte = p0_pend;
		`IOP_IDX_P1_IRQ_PEND: rd_byte = p1_pend;
		`IOP_IDX_P0_DEBOUNCE: rd_byte = p0_debounce;
		`IOP_IDX_P0_KEY_RST:  rd_byte = p0_key_rst;
		`IOP_IDX_P0_FUNC:     rd_byte = p0_func;
		`IOP_IDX_P1_FUNC:     rd_byte = p1_func;
		`IOP_IDX_P2_FUNC:     rd_byte = p2_func;
		`IOP_IDX_P3_FUNC:     rd_byte = p3_func;
		`IOP_IDX_IRQ_STATUS:  rd_byte = {6'h00, irq_status};
		`IOP_IDX_IRQ_MASK:    rd_byte = {6'h00, irq_mask};
		default:              rd_byte = 8'h00;
		endcase
	end

	// ======================================================================
	// APB handshake
	// Data is captured at the end of setup so prdata leaves a flop;
	// the cost is that levels read are one cycle old.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable & ~pwrite)
				prdata <= {24'h000000, rd_byte};
			else if (psel & penable & pready)
				prdata <= 32'h0000_0000;
		end
	end

	// ======================================================================
	// Pad drive
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port0_pin_out     <= `IOP_RST_OUT;
			port1_pin_out     <= `IOP_RST_OUT;
			port2_pin_out     <= `IOP_RST_OUT;
			port3_pin_out     <= 4'h0;
			port0_pin_oe      <= `IOP_RST_DIR;
			port1_pin_oe      <= `IOP_RST_DIR;
			port2_pin_oe      <= `IOP_RST_DIR;
			port3_pin_oe      <= 4'h0;
			pullup_enable     <= 28'hFFFFFFF;
			hysteresis_enable <= 28'h0000000;
			function_select   <= 32'h0000_0000;
			debounce_control  <= `IOP_RST_DEBOUNCE;
			key_reset_config  <= `IOP_RST_KEY_RST;
		end else begin
			port0_pin_out     <= port0_output_value;
			port1_pin_out     <= port1_output_value;
			port2_pin_out     <= port2_output_value;
			port3_pin_out     <= port3_output_value;
			port0_pin_oe      <= p0_dir;
			port1_pin_oe      <= p1_dir;
			port2_pin_oe      <= p2_dir;
			port3_pin_oe      <= p3_dir;
			pullup_enable     <= {p3_pullup, p2_pullup, p1_pullup, p0_pullup};
			hysteresis_enable <= {p3_hyst, p2_hyst, p1_hyst, p0_hyst};
			function_select   <= {p3_func, p2_func, p1_func, p0_func};
			debounce_control  <= p0_debounce;
			key_reset_config  <= p0_key_rst;
		end
	end
endmodule // iop_port_regs
`default_nettype wire

// ===== verification/iop_port_regs_assertions.sv
// Purpose: Concurrent checks on the APB side and the port 0 pins.
// Assumes: Bound to iop_port_regs; pins quiet for 5 cycles before level reads.
// Notes:   Only top-level ports are watched.
`timescale 1ns/10ps
`default_nettype none
module iop_chk #(
	parameter AW = 18
) (
	// Clock and reset
	input wire logic          pclk,
	input wire logic          presetn,
	// APB
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [3:0]    pstrb,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	// Port 0
	input wire logic [7:0]    port0_pin_in,
	input wire logic [7:0]    port0_pin_out,
	input wire logic          port0_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [15:0] idx     = paddr[AW-1:2];
	wire [7:0]  wr_byte = pstrb[0] ? pwdata[7:0] : 8'h00;
	// ====================
	// Transfer phases
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_rd_done;
		psel && penable && pready && !pwrite;
	endsequence
	sequence s_wr_done;
		psel && penable && pready && pwrite;
	endsequence
	// ====================
	// Properties
	chk_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_no_slverr: assert property (pready |-> !pslverr)
		else $error("pslverr raised");
	chk_upper_zero: assert property (s_rd_done |-> prdata[31:8] == 24'h0)
		else $error("read data above bit 7 not zero");
	chk_p3_reserved: assert property (s_rd_done ##0 (idx == 16'h5230) |-> prdata[7:4] == 4'h0)
		else $error("port 3 level upper bits not zero");
	chk_unmapped_zero: assert property (s_rd_done ##0 (idx == 16'h520A || idx == 16'h5225
		|| idx == 16'h52A4) |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_level_sync: assert property (s_rd_done ##0 (idx == 16'h5200
		&& $past(port0_pin_in, 3) == $past(port0_pin_in, 4)
		&& $past(port0_pin_in, 3) == $past(port0_pin_in, 5))
		|-> prdata[7:0] == $past(port0_pin_in, 3))
		else $error("port 0 level read differs from pins");
	chk_pend_mirror: assert property (s_rd_done ##0 (idx == 16'h5207)
		|-> (prdata[7:0] != 8'h0) == $past(port0_irq))
		else $error("port 0 request disagrees with pending flags");
	chk_out_follow: assert property (s_wr_done ##0 (idx == 16'h5201)
		|-> ##2 port0_pin_out == $past(wr_byte, 2))
		else $error("port 0 output pins differ from written value");
endmodule // iop_chk

bind iop_port_regs iop_chk #(.AW(AW)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pin_in(port0_pin_in),
	.port0_pin_out(port0_pin_out), .port0_irq(port0_irq));
`default_nettype wire

// ===== verification/iop_pad_model.sv
// Purpose: External pads of all 28 pins.
// Assumes: Design drive wins; then the outside driver; then the pull-up.
// Notes:   A floating pin without pull-up shows the inverse of the last outside value.
`timescale 1ns/10ps
`default_nettype none
module iop_pad_model #(
	parameter W = 28
) (
	// From the design
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe,
	input  wire logic [W-1:0] pull_en,
	// Outside world
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_en,
	// Resolved level
	output wire logic [W-1:0] level
);
	assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pull_en | ~ext_val));
endmodule // iop_pad_model
`default_nettype wire

// ===== verification/iop_port_regs_tb.sv
// Purpose: Self-checking bench for the port register block.
// Assumes: One idle cycle between APB transfers.
// Notes:   Random data from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module iop_port_regs_tb;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [17:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [27:0] ext_val, ext_en;
	logic [15:0] b;
	logic [7:0]  q, r, en, t, st;
	logic [7:0]  shadow [256];
	wire         pready, pslverr, irq, irq0, irq1;
	wire  [31:0] prdata, fs;
	wire  [27:0] pin_in, pin_out, pin_oe, pu, hy;
	wire  [7:0]  dbc, krc;
	int          err_total = 0, total_checks = 0, cyc = 0;

	iop_port_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port0_pin_in(pin_in[7:0]),
		.port1_pin_in(pin_in[15:8]), .port2_pin_in(pin_in[23:16]),
		.port3_pin_in(pin_in[27:24]), .port0_pin_out(pin_out[7:0]),
		.port1_pin_out(pin_out[15:8]), .port2_pin_out(pin_out[23:16]),
		.port3_pin_out(pin_out[27:24]), .port0_pin_oe(pin_oe[7:0]),
		.port1_pin_oe(pin_oe[15:8]), .port2_pin_oe(pin_oe[23:16]),
		.port3_pin_oe(pin_oe[27:24]), .pullup_enable(pu), .hysteresis_enable(hy),
		.function_select(fs), .debounce_control(dbc), .key_reset_config(krc),
		.port0_irq(irq0), .port1_irq(irq1), .irq(irq));
	iop_pad_model #(.W(28)) pads_u (.pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pu),
		.ext_val(ext_val), .ext_en(ext_en), .level(pin_in));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ====================
	// Map knowledge: 0 hole, 1 read-write, 2 pin level, 3 pending
	function automatic int kind(logic [15:0] i);
		logic [3:0] lo = i[3:0];
		if (i >= 16'h52A0) return (i <= 16'h52A3) ? 1 : 0;
		if (i[7:4] > 4'h3) return 0;
		if (lo == 4'h0) return 2;
		if (lo <= 4'h4) return 1;
		if (i[7:4] > 4'h1) return 0;
		if (lo == 4'h7) return 3;
		if (lo <= 4'h6 || (i[7:4] == 4'h0 && lo <= 4'h9)) return 1;
		return 0;
	endfunction
	function automatic logic [7:0] wmask(logic [15:0] i);
		return (i < 16'h52A0 && i[7:4] == 4'h3) ? 8'h0F : 8'hFF;
	endfunction
	function automatic logic [7:0] rst(logic [15:0] i);
		return (kind(i) == 1 && i[3:0] == 4'h3 && i < 16'h52A0) ? wmask(i) : 8'h00;
	endfunction
	// ====================
	// Bus and compare helpers
	task automatic apb(input logic wr, input logic [15:0] i, input logic [7:0] d);
		int n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {i, 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1) begin
			err_total++;
			$display("unexpected pready expected 1 seen %b", pready);
		end
		q = prdata[7:0];
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(string nm, logic [15:0] i, logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk(nm, e, q);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Hang guard, well above the ~2000 cycles the tests take
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// ====================
	// Tests
	initial begin
		void'($urandom(32'h6D6B));
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		ext_val = 28'h0;
		ext_en = 28'hFFFFFFF;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 16'h5200; i < 16'h52B0; i++)
			if (kind(i[15:0]) != 2) rd("reset", i[15:0], rst(i[15:0]));
		$display("test reset done");
		for (int i = 16'h5200; i < 16'h52B0; i++) begin
			r = 8'($urandom) & wmask(i[15:0]);
			if (kind(i[15:0]) == 3) continue;
			apb(1'b1, i[15:0], r);
			if (kind(i[15:0]) == 1) shadow[i[7:0]] = r;
			if (kind(i[15:0]) != 2) rd("rw", i[15:0], kind(i[15:0]) == 1 ? r : 8'h00);
		end
		for (int p = 0; p < 4; p++) begin
			chk("out", shadow[p * 16 + 1], 8'(pin_out >> (p * 8)));
			chk("oe", shadow[p * 16 + 2], 8'(pin_oe >> (p * 8)));
			chk("pu", shadow[p * 16 + 3], 8'(pu >> (p * 8)));
			chk("hy", shadow[p * 16 + 4], 8'(hy >> (p * 8)));
			chk("fs", shadow[8'hA0 + p], 8'(fs >> (p * 8)));
		end
		chk("dbc", shadow[8'h08], dbc);
		chk("krc", shadow[8'h09], krc);
		pstrb <= 4'hE;
		apb(1'b1, 16'h5221, 8'h5A);
		pstrb <= 4'hF;
		rd("strobe", 16'h5221, 8'h00);
		$display("test registers done");
		for (int p = 0; p < 4; p++) apb(1'b1, 16'h5202 + 16'(p * 16), 8'h00);
		repeat (6) begin
			ext_val <= 28'($urandom);
			repeat (4) @(posedge pclk);
			for (int p = 0; p < 4; p++) begin
				apb(1'b1, 16'h5200 + 16'(p * 16), 8'hFF);
				rd("level", 16'h5200 + 16'(p * 16), 8'(ext_val >> (p * 8)) & (p == 3 ? 8'h0F : 8'hFF));
			end
		end
		apb(1'b1, 16'h5202, 8'hFF);
		apb(1'b1, 16'h5201, 8'hA5);
		repeat (4) @(posedge pclk);
		rd("loopback", 16'h5200, 8'hA5);
		apb(1'b1, 16'h5202, 8'h00);
		apb(1'b1, 16'h5203, 8'hFF);
		ext_en[7:0] <= 8'h00;
		repeat (4) @(posedge pclk);
		rd("pullup", 16'h5200, 8'hFF);
		ext_en <= 28'hFFFFFFF;
		$display("test pins done");
		for (int p = 0; p < 2; p++)
			for (int pol = 0; pol < 2; pol++) begin
				b = 16'h5200 + 16'(p * 16);
				st = pol ? 8'hFF : 8'h00;
				en = 8'($urandom) | 8'h01;
				t = 8'($urandom) | 8'h01;
				apb(1'b1, 16'h5205, 8'h00);
				apb(1'b1, 16'h5215, 8'h00);
				ext_val <= 28'(st) << (p * 8);
				repeat (4) @(posedge pclk);
				apb(1'b1, b + 16'h6, st);
				apb(1'b1, b + 16'h7, 8'hFF);
				apb(1'b1, b + 16'h5, en);
				apb(1'b1, 16'h52B1, pol ? 8'h00 : 8'h03);
				apb(1'b0, 16'h52B0, 8'h00);
				ext_val <= 28'(st ^ t) << (p * 8);
				repeat (4) @(posedge pclk);
				chk("port_irq", 8'h01, {7'h0, p ? irq1 : irq0});
				chk("irq", {7'h0, pol == 0}, {7'h0, irq});
				rd("pending", b + 16'h7, en & t);
				rd("status", 16'h52B0, 8'(1 << p));
				repeat (2) @(posedge pclk);
				chk("irq_clear", 8'h00, {7'h0, irq});
				apb(1'b1, b + 16'h7, 8'h0F);
				rd("w1c", b + 16'h7, en & t & 8'hF0);
				ext_val <= 28'(st) << (p * 8);
				repeat (4) @(posedge pclk);
				rd("opposite", b + 16'h7, en & t & 8'hF0);
				apb(1'b1, b + 16'h7, 8'hFF);
				rd("cleared", b + 16'h7, 8'h00);
			end
		$display("test interrupts done");
		tally_and_finish();
	end
endmodule // iop_port_regs_tb
`default_nettype wire
